// *** logic/epir_top.sv ***
// external pin interrupt request block with AXI4-Lite register slave
// Function
// RULE1: pin acts as request input only while pin enable bit 4 is set.
// RULE2: pull resistor is enabled whenever pin enable is set.
// RULE3: rising-edge polarity with pin enabled turns the pull into pull-down.
// RULE4: polarity bit 5 picks falling/low or rising/high events.
// RULE5: detection mode bit 0 picks edge-only or edge-and-level events.
// RULE6: request flag bit 3 is set by a qualifying event, read-only.
// RULE7: writing one to acknowledge bit 2 clears the request flag.
// RULE8: writing zero to acknowledge does nothing; it always reads zero.
// RULE9: in edge-and-level mode acknowledge cannot clear while pin stays asserted.
// RULE10: interrupt enable bit 1 gates the flag onto the hardware request.
// RULE11: bits 7 and 6 read zero and ignore writes.
// RULE12: pin is synchronised, edges found by comparing samples, ignored when disabled.
// RULE13: reset clears enable, polarity, mode, interrupt enable and the flag.
module epir_top (
	input  wire logic              clk,
	input  wire logic              reset,
	input  epir_pkg::epir_axi_req_t axi_req,
	output epir_pkg::epir_axi_rsp_t axi_rsp,
	input  wire logic              pin_in,
	output logic                   pull_enable,
	output logic                   pull_down_select,
	output logic                   cpu_request,
	output logic                   irq
);
	import epir_pkg::*;

	typedef struct packed {
		logic              pin_enable;
		logic              polarity;
		logic              detection_mode;
		logic              req_ie;
		logic              request_flag;
		logic [EV_W-1:0]   ev_status;
		logic [EV_W-1:0]   ev_mask;
		logic              aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_held;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		epir_axi_rsp_t     rsp;
		logic              pull_enable;
		logic              pull_down_select;
		logic              cpu_request;
		logic              irq;
	} epir_state_t;

	epir_state_t st_reg;
	epir_state_t st_next;
	epir_cfg_t   cfg;
	logic        event_pulse;
	logic        level_asserted;

	// register read decode, shared by read path
	function automatic logic [31:0] read_word(input epir_state_t s, input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			PISC_OFFSET: begin
				v[PIN_ENABLE_BIT]     = s.pin_enable;
				v[POLARITY_BIT]       = s.polarity;
				v[REQ_FLAG_BIT]       = s.request_flag;      // see RULE6
				v[REQ_IE_BIT]         = s.req_ie;
				v[DETECTION_MODE_BIT] = s.detection_mode;    // acknowledge and bits 7:6 stay 0, see RULE8 see RULE11
			end
			EVSTAT_OFFSET: v[EV_W-1:0] = s.ev_status;
			EVMASK_OFFSET: v[EV_W-1:0] = s.ev_mask;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == PISC_OFFSET) || (a == EVSTAT_OFFSET) || (a == EVMASK_OFFSET);
	endfunction

	assign cfg.pin_enable     = st_reg.pin_enable;
	assign cfg.polarity       = st_reg.polarity;
	assign cfg.detection_mode = st_reg.detection_mode;

	epir_detect u_detect (
		.clk            (clk),
		.reset          (reset),
		.pin_in         (pin_in),
		.cfg            (cfg),
		.event_pulse    (event_pulse),
		.level_asserted (level_asserted)
	);

	always_comb begin
		logic        do_write;
		logic        ack_write;
		logic [31:0] wd;
		st_next   = st_reg;
		do_write  = 1'b0;
		ack_write = 1'b0;
		wd        = 32'h0000_0000;

		// write address and data channels, taken in either order
		if (axi_req.awvalid && st_reg.rsp.awready) begin
			st_next.aw_held     = 1'b1;
			st_next.aw_addr     = axi_req.awaddr;
			st_next.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && st_reg.rsp.wready) begin
			st_next.w_held     = 1'b1;
			st_next.w_data     = axi_req.wdata;
			st_next.w_strb     = axi_req.wstrb;
			st_next.rsp.wready = 1'b0;
		end

		// perform write once both halves are held and no response is pending
		if (st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid) begin
			do_write            = 1'b1;
			wd                  = st_reg.w_data;
			st_next.aw_held     = 1'b0;
			st_next.w_held      = 1'b0;
			st_next.rsp.bvalid  = 1'b1;
			st_next.rsp.bresp   = addr_mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.rsp.bvalid && axi_req.bready) begin
			st_next.rsp.bvalid  = 1'b0;
			st_next.rsp.awready = 1'b1;
			st_next.rsp.wready  = 1'b1;
		end

		// register writes, low byte lane only carries fields
		if (do_write && st_reg.w_strb[0]) begin
			unique case (st_reg.aw_addr)
				PISC_OFFSET: begin
					st_next.pin_enable     = wd[PIN_ENABLE_BIT];     // see RULE1
					st_next.polarity       = wd[POLARITY_BIT];       // see RULE4
					st_next.req_ie         = wd[REQ_IE_BIT];         // see RULE10
					st_next.detection_mode = wd[DETECTION_MODE_BIT]; // see RULE5
					ack_write              = wd[REQ_ACK_BIT];        // see RULE8
				end
				EVSTAT_OFFSET: st_next.ev_status = st_reg.ev_status & ~wd[EV_W-1:0];
				EVMASK_OFFSET: st_next.ev_mask   = wd[EV_W-1:0];
				default: ;
			endcase
		end

		// acknowledge clears flag, but a level still asserted holds it in edge-and-level mode
		if (ack_write && !(st_reg.detection_mode && level_asserted)) begin
			st_next.request_flag = 1'b0; // see RULE7 see RULE9
		end
		// set wins over clear
		if (event_pulse) begin
			st_next.request_flag = 1'b1;                                // see RULE6
			st_next.ev_status[EV_REQUEST_BIT] = 1'b1;
		end

		// read channel
		if (axi_req.arvalid && st_reg.rsp.arready) begin
			st_next.rsp.arready = 1'b0;
			st_next.rsp.rvalid  = 1'b1;
			st_next.rsp.rdata   = read_word(st_reg, axi_req.araddr);
			st_next.rsp.rresp   = addr_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.rsp.rvalid && axi_req.rready) begin
			st_next.rsp.rvalid  = 1'b0;
			st_next.rsp.arready = 1'b1;
		end

		// pin outputs and interrupt lines, registered
		st_next.pull_enable      = st_next.pin_enable;                        // see RULE2
		st_next.pull_down_select = st_next.pin_enable & st_next.polarity;     // see RULE3
		st_next.cpu_request      = st_next.req_ie & st_next.request_flag;     // see RULE10
		st_next.irq              = |(st_next.ev_status & st_next.ev_mask);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg             <= '0; // see RULE13
			st_reg.ev_mask     <= EVMASK_RESET;
			st_reg.rsp.awready <= 1'b1;
			st_reg.rsp.wready  <= 1'b1;
			st_reg.rsp.arready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign axi_rsp          = st_reg.rsp;
	assign pull_enable      = st_reg.pull_enable;
	assign pull_down_select = st_reg.pull_down_select;
	assign cpu_request      = st_reg.cpu_request;
	assign irq              = st_reg.irq;
endmodule

// *** include/epir_pkg.sv ***
// package for the external pin interrupt request block: register map, fields, reset values, types
package epir_pkg;

	localparam int ADDR_W = 4;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [ADDR_W-1:0] PISC_OFFSET  = 4'h0;
	localparam logic [ADDR_W-1:0] EVSTAT_OFFSET = 4'h4;
	localparam logic [ADDR_W-1:0] EVMASK_OFFSET = 4'h8;

	// pin_interrupt_status_control fields
	localparam int DETECTION_MODE_BIT = 0;
	localparam int REQ_IE_BIT         = 1;
	localparam int REQ_ACK_BIT        = 2;
	localparam int REQ_FLAG_BIT       = 3;
	localparam int PIN_ENABLE_BIT     = 4;
	localparam int POLARITY_BIT       = 5;

	// event status and mask: bit 0 is the pin request event
	localparam int EV_REQUEST_BIT = 0;
	localparam int EV_W           = 1;

	localparam logic [7:0]      PISC_RESET   = 8'h00;
	localparam logic [EV_W-1:0] EVMASK_RESET = 1'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} epir_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} epir_axi_rsp_t;

	// pin configuration as seen by the detector
	typedef struct packed {
		logic pin_enable;
		logic polarity;
		logic detection_mode;
	} epir_cfg_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic prev_valid;
	} epir_det_state_t;

endpackage

// *** logic/epir_detect.sv ***
// pin synchroniser and qualifying-event detector
module epir_detect (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              pin_in,
	input  epir_pkg::epir_cfg_t    cfg,
	output logic                   event_pulse,
	output logic                   level_asserted
);
	import epir_pkg::*;

	epir_det_state_t st_reg;
	epir_det_state_t st_next;
	logic            asserted_now;
	logic            asserted_prev;

	always_comb begin
		st_next            = st_reg;
		st_next.sync1      = pin_in;
		st_next.sync2      = st_reg.sync1;
		st_next.prev       = st_reg.sync2;
		st_next.prev_valid = cfg.pin_enable;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// asserted level: high when rising polarity, else low
	assign asserted_now  = cfg.polarity ? st_reg.sync2 : ~st_reg.sync2; // see RULE4
	assign asserted_prev = cfg.polarity ? st_reg.prev : ~st_reg.prev;   // see RULE12

	// edge needs one enabled cycle of history so enabling never fakes an edge
	assign level_asserted = cfg.pin_enable & asserted_now; // see RULE1
	assign event_pulse    = cfg.pin_enable & asserted_now &
		((st_reg.prev_valid & ~asserted_prev) | cfg.detection_mode); // see RULE5
endmodule

// *** bench/epir_pin_src.sv ***
// far-side pin source with pull resistor behaviour
module epir_pin_src (
	input  wire logic clk,
	input  wire logic drive_en,
	input  wire logic drive_lvl,
	input  wire logic pull_enable,
	input  wire logic pull_down_select,
	output logic      pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic alt_reg = 1'b0;
	always @(posedge clk) alt_reg <= ~alt_reg;
	// a released pin follows the pull, else it wanders every cycle
	assign pin_in = drive_en ? drive_lvl : pull_enable ? ~pull_down_select : alt_reg;
endmodule

// *** bench/epir_top_props.sv ***
// assertion checker for the pin interrupt request block
module epir_top_props (
	input wire logic              clk,
	input wire logic              reset,
	input epir_pkg::epir_axi_req_t axi_req,
	input epir_pkg::epir_axi_rsp_t axi_rsp,
	input wire logic              pin_in,
	input wire logic              pull_enable,
	input wire logic              pull_down_select,
	input wire logic              cpu_request,
	input wire logic              irq
);
	import epir_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_PULL_DIR: assert property (pull_down_select |-> pull_enable) else $error("pull-down without pull");
	AST_HI_ZERO: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[7:6] == 2'h0) else $error("upper bits set");
	AST_ACK_ZERO: assert property (axi_rsp.rvalid |-> !axi_rsp.rdata[2]) else $error("ack reads one");
	AST_RST_QUIET: assert property ($past(reset) |->
		!(cpu_request | irq | pull_enable | pull_down_select)) else $error("output up after reset");
	// an event rise needs the pin enabled in the cycle that saw it; register writes answer with bvalid
	AST_IRQ_PIN: assert property ($rose(irq) && !axi_rsp.bvalid |-> $past(pull_enable))
		else $error("event while pin off");
	AST_RD_LAT: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read late");
	AST_WR_LAT: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
		|-> ##2 axi_rsp.bvalid) else $error("write late");
	AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("response dropped");
	cover property ($rose(cpu_request));
	cover property ($rose(irq));
	cover property (pull_down_select);
endmodule

bind epir_top epir_top_props CHK (.clk(clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.pin_in(pin_in), .pull_enable(pull_enable), .pull_down_select(pull_down_select),
	.cpu_request(cpu_request), .irq(irq));

// *** bench/tb_top.sv ***
// self-checking testbench for the pin interrupt request block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import epir_pkg::*;
	logic          clk = 1'b0, reset = 1'b1, src_en = 1'b1, src_lvl = 1'b0;
	logic          pin_in, pull_enable, pull_down_select, cpu_request, irq;
	epir_axi_req_t req = '0;
	epir_axi_rsp_t rsp;
	int            error_cnt = 0, n_checks = 0;
	always #20 clk = ~clk;
	epir_top DUT (.clk(clk), .reset(reset), .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in), .irq(irq),
		.pull_enable(pull_enable), .pull_down_select(pull_down_select), .cpu_request(cpu_request));
	epir_pin_src SRC (.clk(clk), .drive_en(src_en), .drive_lvl(src_lvl), .pull_enable(pull_enable),
		.pull_down_select(pull_down_select), .pin_in(pin_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		req.awaddr <= a; req.wdata <= d; req.wstrb <= 4'hF;
		req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		chk({30'h0, rsp.bresp}, (a > 4'h8) ? 32'h2 : 32'h0);
		req.bready <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		chk(rsp.rdata, exp);
		chk({30'h0, rsp.rresp}, (a > 4'h8) ? 32'h2 : 32'h0);
		req.rready <= 1'b0;
	endtask
	task automatic pin(input logic v, input logic en);
		@(posedge clk);
		src_lvl <= v; src_en <= en;
		repeat (5) @(posedge clk);
	endtask
	task automatic t_regs;
		rchk(PISC_OFFSET, 32'h0);
		rchk(EVMASK_OFFSET, 32'h0);
		rchk(4'hC, 32'h0);
		wr(4'hC, 32'hFF);
		wr(PISC_OFFSET, 32'hFF);
		rchk(PISC_OFFSET, 32'h33);
		chk({30'h0, pull_enable, pull_down_select}, 32'h3);
		$display("test regs done");
	endtask
	task automatic t_edge(input logic pol);
		logic [31:0] c;
		c = pol ? 32'h32 : 32'h12;
		wr(PISC_OFFSET, 32'h0);
		pin(~pol, 1'b1);
		wr(PISC_OFFSET, c);
		pin(pol, 1'b1);
		rchk(PISC_OFFSET, c | 32'h8);
		chk(32'(cpu_request), 32'h1);
		wr(PISC_OFFSET, c);
		rchk(PISC_OFFSET, c | 32'h8);
		wr(PISC_OFFSET, c | 32'h4);
		rchk(PISC_OFFSET, c);
		chk(32'(cpu_request), 32'h0);
		pin(~pol, 1'b1);
		rchk(PISC_OFFSET, c);
		$display("test edge %0d done", pol);
	endtask
	task automatic t_level;
		pin(1'b1, 1'b1);
		wr(PISC_OFFSET, 32'h15);
		rchk(PISC_OFFSET, 32'h11);
		pin(1'b0, 1'b1);
		wr(PISC_OFFSET, 32'h15);
		rchk(PISC_OFFSET, 32'h19);
		chk(32'(cpu_request), 32'h0);
		pin(1'b1, 1'b1);
		wr(PISC_OFFSET, 32'h15);
		rchk(PISC_OFFSET, 32'h11);
		$display("test level done");
	endtask
	task automatic t_irq;
		chk(32'(irq), 32'h0);
		wr(EVMASK_OFFSET, 32'h1);
		rchk(EVSTAT_OFFSET, 32'h1);
		chk(32'(irq), 32'h1);
		wr(EVSTAT_OFFSET, 32'h1);
		rchk(EVSTAT_OFFSET, 32'h0);
		chk(32'(irq), 32'h0);
		wr(PISC_OFFSET, 32'h0);
		pin(1'b0, 1'b0);
		pin(1'b1, 1'b1);
		pin(1'b0, 1'b1);
		rchk(PISC_OFFSET, 32'h0);
		rchk(EVSTAT_OFFSET, 32'h0);
		pin(1'b1, 1'b1);
		wr(PISC_OFFSET, 32'h12);
		pin(1'b0, 1'b1);
		chk(32'(irq), 32'h1);
		chk(32'(cpu_request), 32'h1);
		rchk(EVSTAT_OFFSET, 32'h1);
		$display("test irq done");
	endtask
	task automatic t_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		chk({28'h0, cpu_request, irq, pull_enable, pull_down_select}, 32'h0);
		rchk(PISC_OFFSET, 32'h0);
		rchk(EVMASK_OFFSET, 32'h0);
		$display("test reset done");
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_edge(1'b0);
		t_edge(1'b1);
		t_level();
		t_irq();
		t_reset();
		test_done();
	end
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule
